// ===== design/vih_pkg.sv
// How it works
// - Twenty-two interrupt sources, each assignable to low or high priority.
// - Sources 0-11 come from on-chip peripherals, 12-21 from external pins.
// - A source's valid condition sets its pending flag to one.
// - Flags set even when disabled; disabled flags raise no request.
// - Enabled set flag raises request; sequencer then long-calls the source vector.
// - Return instruction ends service so program flow resumes where it left.
// - Global enable bit 7 must be one before any source enable counts.
// - Only listed sources auto-clear on vectoring; software clears the rest.
// - Flag still set after return re-requests after one further instruction.
// - Software writing one to a pending flag acts as a real event.
// - High request preempts low routine; high routine is never preempted.
// - Higher level wins; equal levels resolved by fixed source order.
// - Pending flags are sampled and decoded on every clock cycle.
// - Requests wait while equal or higher routine runs, plus one instruction.
package vih_pkg;

    // Source counts
    localparam int NUM_SRC    = 22;
    localparam int NUM_PERIPH = 12;
    localparam int NUM_EXT    = 10;

    // Register byte offsets
    localparam logic [7:0] OFS_PEND     = 8'h00;
    localparam logic [7:0] OFS_PEND_SET = 8'h04;
    localparam logic [7:0] OFS_PEND_CLR = 8'h08;
    localparam logic [7:0] OFS_IRQ_EN   = 8'h0C;
    localparam logic [7:0] OFS_EXT_EN1  = 8'h10;
    localparam logic [7:0] OFS_EXT_EN2  = 8'h14;
    localparam logic [7:0] OFS_PRIO     = 8'h18;
    localparam logic [7:0] OFS_STATUS   = 8'h1C;

    // Field positions
    localparam int GLOBAL_EN_BIT = 7;
    localparam int IRQ_EN_SRCS   = 6;

    // Reset values
    localparam logic [21:0] RST_PEND = 22'h000000;
    localparam logic [21:0] RST_PRIO = 22'h000000;
    localparam logic [7:0]  RST_EN   = 8'h00;

    // Sources cleared by hardware when vectored; edge-type external inputs
    localparam logic [21:0] AUTO_CLEAR_MASK  = 22'h3FF000;
    // External inputs bonded out in this variant
    localparam logic [9:0]  EXT_PRESENT_MASK = 10'h3FF;

    // Vector table: base plus fixed stride per source
    localparam logic [15:0] VEC_BASE = 16'h0003;
    localparam logic [15:0] VEC_STEP = 16'h0008;

    // Bus response
    localparam logic HRESP_OKAY = 1'b0;

    // In-service state
    typedef enum logic [1:0] {
        SVC_IDLE     = 2'b00,
        SVC_LOW      = 2'b01,
        SVC_HIGH     = 2'b10,
        SVC_HIGH_LOW = 2'b11
    } vih_svc_t;

    // Vector address of one source
    function automatic logic [15:0] vih_vector(input logic [4:0] id);
        logic [15:0] off;
        off = VEC_STEP * {11'h000, id};
        return 16'(VEC_BASE + off);
    endfunction : vih_vector

endpackage : vih_pkg

// ===== design/vih_arb_if.sv
`timescale 1ns/1ns
`default_nettype none
// Request vectors in, winning source out
interface vih_arb_if;
    logic [21:0] reqHigh;
    logic [21:0] reqLow;
    logic        winValid;
    logic        winHigh;
    logic [4:0]  winId;

    modport ctrl (output reqHigh, output reqLow, input winValid, input winHigh, input winId);
    modport arb  (input reqHigh, input reqLow, output winValid, output winHigh, output winId);
endinterface : vih_arb_if
`default_nettype wire

// ===== design/vih_ext_sync.sv
`timescale 1ns/1ns
`default_nettype none
module vih_ext_sync
    import vih_pkg::*;
(
    // Clock and reset
    input  wire logic               ref_clk,
    input  wire logic               arst_n,
    // Active-low pins and falling-edge pulses
    input  wire logic [NUM_EXT-1:0] extIrqN,
    output logic      [NUM_EXT-1:0] extFall
);

    logic [NUM_EXT-1:0] meta_reg;
    logic [NUM_EXT-1:0] sync_reg;
    logic [NUM_EXT-1:0] prev_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // Per-pin two-flop synchroniser and edge detector
    genvar g;
    generate
        for (g = 0; g < NUM_EXT; g++) begin : gPin
            always_ff @(posedge ref_clk or negedge arst_n) begin
                if (!arst_n) begin
                    meta_reg[g] <= 1'b1;
                    sync_reg[g] <= 1'b1;
                    prev_reg[g] <= 1'b1;
                end else begin
                    meta_reg[g] <= extIrqN[g];
                    sync_reg[g] <= meta_reg[g];
                    prev_reg[g] <= sync_reg[g];
                end
            end
            assign extFall[g] = prev_reg[g] & ~sync_reg[g]; // High-to-low edge
        end
    endgenerate

endmodule : vih_ext_sync
`default_nettype wire

// ===== design/vih_arbiter.sv
`timescale 1ns/1ns
`default_nettype none
module vih_arbiter
    import vih_pkg::*;
(
    // Request vectors and winner
    vih_arb_if.arb arb
);

    ////////////////////////////////////////////////////////////////////////////////
    // High level first, lowest index first within a level
    always_comb begin
        arb.winValid = 1'b0;
        arb.winHigh  = 1'b0;
        arb.winId    = 5'h00;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (arb.reqLow[i]) begin
                arb.winValid = 1'b1;
                arb.winId    = 5'(i);
            end
        end
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (arb.reqHigh[i]) begin
                arb.winValid = 1'b1;
                arb.winHigh  = 1'b1;
                arb.winId    = 5'(i);
            end
        end
    end

endmodule : vih_arbiter
`default_nettype wire

// ===== design/vih_top.sv
`timescale 1ns/1ns
`default_nettype none
module vih_top
    import vih_pkg::*;
(
    // Clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  arst_n,
    // AHB-Lite slave
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic                       hreadyout,
    output logic                       hresp,
    output logic      [31:0]           hrdata,
    // Interrupt sources
    input  wire logic [NUM_PERIPH-1:0] periphEvent,
    input  wire logic [NUM_EXT-1:0]    extIrqN,
    // CPU sequencer
    output logic                       irqReq,
    output logic      [15:0]           irqVector,
    output logic                       irqLevelHigh,
    input  wire logic                  irqAck,
    input  wire logic                  instrDone,
    input  wire logic                  retiDone
);

    logic [21:0]  pend_reg;
    logic [21:0]  pend_next;
    logic [21:0]  prio_reg;
    logic [7:0]   irqEn_reg;
    logic [7:0]   extEn1_reg;
    logic [7:0]   extEn2_reg;
    logic         wrActive_reg;
    logic [7:0]   wrAddr_reg;
    logic [31:0]  hrdata_reg;
    logic         irqReq_reg;
    logic         irqReq_next;
    logic [15:0]  irqVector_reg;
    logic         irqHigh_reg;
    logic [4:0]   reqId_reg;
    logic         holdoff_reg;
    vih_svc_t     svc_reg;
    vih_svc_t     svc_next;
    logic [9:0]   extFall;
    logic [21:0]  hwSet;
    logic [21:0]  swSet;
    logic [21:0]  anyClr;
    logic [21:0]  srcEnable;
    logic [21:0]  armed;
    logic         globalEn;
    logic         allowLow;
    logic         allowHigh;
    logic         ackTake;
    logic         gate;
    logic         addrPhase;
    logic [31:0]  readMux;

    vih_arb_if arbBus ();

    ////////////////////////////////////////////////////////////////////////////////
    // External pin synchroniser and priority arbiter
    vih_ext_sync uSync (
        .ref_clk (ref_clk),
        .arst_n  (arst_n),
        .extIrqN (extIrqN),
        .extFall (extFall)
    );

    vih_arbiter uArb (
        .arb (arbBus.arb)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // AHB-Lite address phase capture; zero wait states
    assign addrPhase = hsel & htrans[1] & hready;
    assign hreadyout = 1'b1;
    assign hresp     = HRESP_OKAY;
    assign hrdata    = hrdata_reg;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            wrActive_reg <= 1'b0;
            wrAddr_reg   <= 8'h00;
        end else begin
            wrActive_reg <= addrPhase & hwrite;
            wrAddr_reg   <= addrPhase ? haddr[7:0] : wrAddr_reg;
        end
    end

    // Read multiplexer; unmapped reads give zero
    always_comb begin
        case (haddr[7:0])
            OFS_PEND:    readMux = {10'h000, pend_reg};
            OFS_IRQ_EN:  readMux = {24'h000000, irqEn_reg[7], 1'b0, irqEn_reg[5:0]};
            OFS_EXT_EN1: readMux = {24'h000000, extEn1_reg};
            OFS_EXT_EN2: readMux = {24'h000000, extEn2_reg};
            OFS_PRIO:    readMux = {10'h000, prio_reg};
            OFS_STATUS:  readMux = {22'h000000, svc_reg, holdoff_reg, irqReq_reg, 1'b0,
                                    reqId_reg};
            default:     readMux = 32'h00000000;
        endcase
    end

    // Read data latched at the address phase
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            hrdata_reg <= 32'h00000000;
        end else if (addrPhase && !hwrite) begin
            hrdata_reg <= readMux;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Enable and priority registers written in the data phase
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            irqEn_reg  <= RST_EN;
            extEn1_reg <= RST_EN;
            extEn2_reg <= RST_EN;
            prio_reg   <= RST_PRIO;
        end else if (wrActive_reg) begin
            case (wrAddr_reg)
                OFS_IRQ_EN:  irqEn_reg  <= {hwdata[7], 1'b0, hwdata[5:0]};
                OFS_EXT_EN1: extEn1_reg <= hwdata[7:0];
                OFS_EXT_EN2: extEn2_reg <= hwdata[7:0];
                OFS_PRIO:    prio_reg   <= hwdata[21:0];
                default:     prio_reg   <= prio_reg;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pending flags: hardware set, software set and clear, auto-clear
    assign hwSet  = {extFall & EXT_PRESENT_MASK, periphEvent};
    assign swSet  = (wrActive_reg && wrAddr_reg == OFS_PEND_SET) ? hwdata[21:0] : 22'h000000;
    assign ackTake = irqAck & irqReq_reg;

    always_comb begin
        anyClr = 22'h000000;
        if (wrActive_reg && wrAddr_reg == OFS_PEND_CLR) begin
            anyClr = hwdata[21:0];
        end
        if (ackTake && AUTO_CLEAR_MASK[reqId_reg]) begin
            anyClr[reqId_reg] = 1'b1;
        end
        pend_next = (pend_reg & ~anyClr) | hwSet | swSet;
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pend_reg <= RST_PEND;
        end else begin
            pend_reg <= pend_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Gating by enables and by the level in service
    assign globalEn  = irqEn_reg[GLOBAL_EN_BIT];
    assign srcEnable = {extEn2_reg, extEn1_reg, irqEn_reg[IRQ_EN_SRCS-1:0]};
    assign armed     = globalEn ? (pend_reg & srcEnable) : 22'h000000;
    assign allowHigh = (svc_reg == SVC_IDLE) || (svc_reg == SVC_LOW);
    assign allowLow  = (svc_reg == SVC_IDLE);
    assign arbBus.reqHigh = allowHigh ? (armed & prio_reg) : 22'h000000;
    assign arbBus.reqLow  = allowLow ? (armed & ~prio_reg) : 22'h000000;

    // After a return, hold off until one further instruction completes
    assign gate = retiDone | (holdoff_reg & ~instrDone);

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            holdoff_reg <= 1'b0;
        end else if (retiDone) begin
            holdoff_reg <= 1'b1;
        end else if (instrDone) begin
            holdoff_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // In-service level tracking
    always_comb begin
        svc_next = svc_reg;
        case (svc_reg)
            SVC_IDLE: begin
                if (ackTake) begin
                    svc_next = irqHigh_reg ? SVC_HIGH : SVC_LOW;
                end
            end
            SVC_LOW: begin
                if (ackTake && irqHigh_reg) begin
                    svc_next = SVC_HIGH_LOW;
                end else if (retiDone) begin
                    svc_next = SVC_IDLE;
                end
            end
            SVC_HIGH: begin
                if (retiDone) begin
                    svc_next = SVC_IDLE;
                end
            end
            SVC_HIGH_LOW: begin
                if (retiDone) begin
                    svc_next = SVC_LOW;
                end
            end
            default: svc_next = SVC_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            svc_reg <= SVC_IDLE;
        end else begin
            svc_reg <= svc_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Request strobe and vector, re-decoded every cycle
    assign irqReq_next = arbBus.winValid & ~gate & ~ackTake;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            irqReq_reg    <= 1'b0;
            irqHigh_reg   <= 1'b0;
            reqId_reg     <= 5'h00;
            irqVector_reg <= 16'h0000;
        end else begin
            irqReq_reg <= irqReq_next;
            if (irqReq_next) begin
                irqHigh_reg   <= arbBus.winHigh;
                reqId_reg     <= arbBus.winId;
                irqVector_reg <= vih_vector(arbBus.winId);
            end
        end
    end

    assign irqReq       = irqReq_reg;
    assign irqVector    = irqVector_reg;
    assign irqLevelHigh = irqHigh_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    sequence sAck;
        irqAck && irqReq;
    endsequence

    sequence sRetiThenWait;
        retiDone ##1 !instrDone;
    endsequence

    AST_HW_SET: assert property ((|hwSet) |=> ((pend_reg & $past(hwSet)) == $past(hwSet)))
        else $error("hardware event did not set its pending flag");

    AST_DISABLED: assert property ((armed == 22'h000000) |=> !irqReq)
        else $error("request raised with no enabled pending flag");

    AST_GLOBAL_OFF: assert property (!irqEn_reg[GLOBAL_EN_BIT] |=> !irqReq)
        else $error("request raised while global enable is off");

    AST_VECTOR: assert property (irqReq |-> irqVector == vih_vector(reqId_reg))
        else $error("vector does not match requesting source");

    AST_AUTOCLR: assert property (
        (sAck and (AUTO_CLEAR_MASK[reqId_reg] && !hwSet[reqId_reg] && !swSet[reqId_reg]))
        |=> !pend_reg[$past(reqId_reg)])
        else $error("auto-clear source still pending after vectoring");

    AST_RETURN_FROM_IRQ_INSTR_WAIT: assert property (sRetiThenWait |-> !irqReq ##1 !irqReq)
        else $error("request raised before one instruction after return");

    AST_REISSUE: assert property (
        (holdoff_reg && instrDone && !retiDone && arbBus.winValid && !ackTake) |=> irqReq)
        else $error("pending flag not re-requested after one instruction");

    AST_HIGH_LOCK: assert property (
        (svc_reg == SVC_HIGH || svc_reg == SVC_HIGH_LOW) |-> !irqReq)
        else $error("request raised during high level service");

    AST_PREEMPT: assert property (
        (svc_reg == SVC_LOW && |arbBus.reqHigh && !gate && !ackTake && !retiDone)
        |=> irqReq && irqLevelHigh)
        else $error("high request failed to preempt low routine");

    AST_LATENCY: assert property (
        (svc_reg == SVC_IDLE && |armed && !gate && !ackTake) |=> irqReq)
        else $error("armed flag not requested on next cycle");

    AST_SW_SET: assert property (
        (|swSet) |=> ((pend_reg & $past(swSet)) == $past(swSet)))
        else $error("software write did not set pending flag");

    AST_LOW_WAIT: assert property ((svc_reg == SVC_LOW) |-> !(irqReq && !irqLevelHigh))
        else $error("low request raised during low service");

    // Service level entry, nesting and return; holdoff, flag keeping and arbitration order
    AST_ACK_DROP: assert property (
        ackTake |=> !irqReq)
        else $error("request not dropped after acknowledge");

    AST_ENTER_LOW: assert property (
        (svc_reg == SVC_IDLE && ackTake && !irqHigh_reg) |=> svc_reg == SVC_LOW)
        else $error("low service not entered");

    AST_NEST: assert property (
        (svc_reg == SVC_LOW && ackTake && irqHigh_reg) |=> svc_reg == SVC_HIGH_LOW)
        else $error("high service did not nest over low");

    AST_RET_LOW: assert property (
        (svc_reg == SVC_LOW && retiDone && !ackTake) |=> svc_reg == SVC_IDLE)
        else $error("return from low service not taken");

    AST_RET_NEST: assert property (
        (svc_reg == SVC_HIGH_LOW && retiDone) |=> svc_reg == SVC_LOW)
        else $error("return did not resume low service");

    AST_HOLD_SET: assert property (
        retiDone |=> holdoff_reg)
        else $error("return did not start holdoff");

    AST_KEEP_FLAG: assert property (
        (ackTake && pend_reg[reqId_reg] && !AUTO_CLEAR_MASK[reqId_reg]
         && !(wrActive_reg && wrAddr_reg == OFS_PEND_CLR)) |=> pend_reg[$past(reqId_reg)])
        else $error("flag left to software was cleared");

    AST_HIGH_WINS: assert property (
        (irqReq_next && |arbBus.reqHigh) |=> irqLevelHigh)
        else $error("low request chosen over high");

    AST_FIXED_ORDER: assert property (
        (irqReq_next && arbBus.reqLow[0] && !(|arbBus.reqHigh)) |=> reqId_reg == 5'h00)
        else $error("lowest index did not win");

endmodule : vih_top
`default_nettype wire

// ===== testbench/vih_seq_model.sv
`timescale 1ns/1ns
`default_nettype none
module vih_seq_model (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        arst_n,
    // Handler link
    input  wire logic        irqReq,
    input  wire logic [15:0] irqVector,
    output logic             irqAck,
    output logic             instrDone,
    output logic             retiDone,
    // Bench control and record
    input  wire logic        ackSlow,
    input  wire logic        retiCmd,
    output logic      [15:0] takenVec,
    output logic      [7:0]  takenCnt
);
    logic [1:0] instCnt;
    logic [1:0] waitCnt;
    logic [1:0] depth;

    ////////////////////////////////////////////////////////////////////////////
    // Instruction stream, restarted by a return so the next one ends later
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            instCnt   <= 2'h0;
            instrDone <= 1'b0;
        end else if (retiCmd && depth != 2'h0) begin
            instCnt   <= 2'h0;
            instrDone <= 1'b0;
        end else begin
            instCnt   <= instCnt + 2'h1;
            instrDone <= (instCnt == 2'h3);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Long call on a standing request, promptly or after a wait; returns
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            irqAck   <= 1'b0;
            retiDone <= 1'b0;
            waitCnt  <= 2'h0;
            depth    <= 2'h0;
            takenVec <= 16'h0000;
            takenCnt <= 8'h00;
        end else begin
            retiDone <= retiCmd && depth != 2'h0;
            if (irqAck) begin
                irqAck <= 1'b0;
                // Only a call if the request still stood
                if (irqReq) begin
                    takenVec <= irqVector;
                    takenCnt <= takenCnt + 8'h01;
                    depth    <= depth + 2'h1;
                end
            end else if (irqReq && (!ackSlow || waitCnt == 2'h3)) begin
                irqAck  <= 1'b1;
                waitCnt <= 2'h0;
            end else begin
                waitCnt <= irqReq ? waitCnt + 2'h1 : 2'h0;
                if (retiCmd && depth != 2'h0) begin
                    depth <= depth - 2'h1;
                end
            end
        end
    end
endmodule : vih_seq_model
`default_nettype wire

// ===== testbench/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb import vih_pkg::*;;
    logic        ref_clk     = 1'b0;
    logic        arst_n      = 1'b0;
    logic        hsel        = 1'b0;
    logic [31:0] haddr       = 32'h00000000;
    logic [1:0]  htrans      = 2'h0;
    logic        hwrite      = 1'b0;
    logic [31:0] hwdata      = 32'h00000000;
    logic [11:0] periphEvent = 12'h000;
    logic [9:0]  extIrqN     = 10'h3FF;
    logic        ackSlow     = 1'b0;
    logic        retiCmd     = 1'b0;
    logic        hreadyout, hresp, irqReq, irqLevelHigh, irqAck, instrDone, retiDone;
    logic [31:0] hrdata;
    logic [15:0] irqVector, takenVec;
    logic [7:0]  takenCnt;
    int          error_cnt = 0;
    int          samples_checked = 0;

    // Clock
    always #20 ref_clk = ~ref_clk;

    vih_top dut_u (.ref_clk(ref_clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .periphEvent(periphEvent),
        .extIrqN(extIrqN), .irqReq(irqReq), .irqVector(irqVector),
        .irqLevelHigh(irqLevelHigh), .irqAck(irqAck), .instrDone(instrDone),
        .retiDone(retiDone));
    vih_seq_model seq_u (.ref_clk(ref_clk), .arst_n(arst_n), .irqReq(irqReq),
        .irqVector(irqVector), .irqAck(irqAck), .instrDone(instrDone), .retiDone(retiDone),
        .ackSlow(ackSlow), .retiCmd(retiCmd), .takenVec(takenVec), .takenCnt(takenCnt));

    ////////////////////////////////////////////////////////////////////////////
    // Verdict
    task automatic tally_and_finish;
        $display("checks %0d, mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : tally_and_finish

    // Compare tasks
    task automatic chk_word(input logic [31:0] exp, input logic [31:0] got, input string m);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: %s exp %h got %h", $time, m, exp, got);
        end
    endtask : chk_word

    task automatic chk_flag(input logic exp, input logic got, input string m);
        chk_word({31'h0, exp}, {31'h0, got}, m);
    endtask : chk_flag

    function automatic logic [15:0] exp_vec(input int id);
        return 16'h0003 + 16'(id * 8);
    endfunction : exp_vec

    ////////////////////////////////////////////////////////////////////////////
    // Bus cycles: address phase held until hready, then data phase
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge ref_clk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {24'h000000, a};
        hwrite <= wr;
        do @(posedge ref_clk); while (hreadyout !== 1'b1 && ++n < 50);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge ref_clk); while (hreadyout !== 1'b1 && ++n < 50);
        rd = hrdata;
        hsel <= 1'b0;
        chk_flag(1'b0, hresp, "response");
        if (n >= 50) chk_flag(1'b1, 1'b0, "bus stalled");
    endtask : ahb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        ahb(1'b1, a, d, rd);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        ahb(1'b0, a, 32'h00000000, rd);
        chk_word(exp, rd, "register read");
    endtask : rd_chk

    // Sequencer helpers
    task automatic take_chk(input logic [7:0] c0, input logic [15:0] v);
        int n;
        n = 0;
        do @(negedge ref_clk); while (takenCnt === c0 && ++n < 60);
        chk_flag(1'b1, takenCnt !== c0, "no service taken");
        chk_word({16'h0000, v}, {16'h0000, takenVec}, "vector taken");
    endtask : take_chk

    task automatic quiet(input int cyc);
        logic [7:0] c0;
        c0 = takenCnt;
        repeat (cyc) @(negedge ref_clk);
        chk_word({24'h0, c0}, {24'h0, takenCnt}, "unexpected service");
    endtask : quiet

    task automatic return_from_irq_instr(input logic hold);
        int n;
        n = 0;
        @(posedge ref_clk);
        retiCmd <= 1'b1;
        @(posedge ref_clk);
        retiCmd <= 1'b0;
        // Request must stay down until an instruction has ended
        if (hold) do begin
            @(negedge ref_clk);
            chk_flag(1'b0, irqReq, "request during holdoff");
        end while (instrDone !== 1'b1 && ++n < 20);
        if (n >= 20) chk_flag(1'b1, 1'b0, "no instruction after return");
    endtask : return_from_irq_instr

    ////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_regs;
        logic [7:0] ofs [6] = '{OFS_PEND, OFS_PEND_SET, OFS_IRQ_EN, OFS_PRIO, OFS_STATUS, 8'h20};
        foreach (ofs[i]) rd_chk(ofs[i], 32'h00000000);
        wr(OFS_IRQ_EN, 32'h000000FF);
        rd_chk(OFS_IRQ_EN, 32'h000000BF);
        wr(OFS_IRQ_EN, 32'h00000000);
        wr(8'h20, 32'hFFFFFFFF);
        rd_chk(8'h20, 32'h00000000);
        $display("test regs done");
    endtask : t_regs

    task automatic t_gate;
        logic [7:0] c0;
        @(posedge ref_clk);
        periphEvent <= 12'h001;
        @(posedge ref_clk);
        periphEvent <= 12'h000;
        rd_chk(OFS_PEND, 32'h00000001);
        quiet(8);
        wr(OFS_IRQ_EN, 32'h00000001);
        quiet(8);
        c0 = takenCnt;
        wr(OFS_IRQ_EN, 32'h00000081);
        take_chk(c0, exp_vec(0));
        rd_chk(OFS_PEND, 32'h00000001);
        c0 = takenCnt;
        return_from_irq_instr(1'b1);
        take_chk(c0, exp_vec(0));
        wr(OFS_PEND_CLR, 32'h00000001);
        return_from_irq_instr(1'b0);
        quiet(10);
        $display("test gate done");
    endtask : t_gate

    task automatic t_prio;
        logic [7:0] c0;
        int         n;
        n = 0;
        ackSlow <= 1'b1;
        wr(OFS_IRQ_EN, 32'h000000A8);
        c0 = takenCnt;
        wr(OFS_PEND_SET, 32'h00000028);
        take_chk(c0, exp_vec(3));
        quiet(10);
        c0 = takenCnt;
        wr(OFS_PRIO, 32'h00000020);
        do @(negedge ref_clk); while (irqReq !== 1'b1 && ++n < 30);
        chk_flag(1'b1, irqLevelHigh, "high level");
        chk_word({16'h0, exp_vec(5)}, {16'h0, irqVector}, "vector shown");
        take_chk(c0, exp_vec(5));
        rd_chk(OFS_STATUS, 32'h00000305);
        wr(OFS_PRIO, 32'h00000028);
        quiet(10);
        wr(OFS_PEND_CLR, 32'h00000028);
        return_from_irq_instr(1'b0);
        return_from_irq_instr(1'b0);
        wr(OFS_PRIO, 32'h00000000);
        ackSlow <= 1'b0;
        $display("test prio done");
    endtask : t_prio

    task automatic t_ext;
        logic [7:0] c0;
        wr(OFS_EXT_EN1, 32'h00000060);
        c0 = takenCnt;
        @(posedge ref_clk);
        extIrqN <= 10'h3FE;
        take_chk(c0, exp_vec(12));
        rd_chk(OFS_PEND, 32'h00000000);
        extIrqN <= 10'h3FF;
        return_from_irq_instr(1'b0);
        c0 = takenCnt;
        @(posedge ref_clk);
        periphEvent <= 12'h800;
        @(posedge ref_clk);
        periphEvent <= 12'h000;
        take_chk(c0, exp_vec(11));
        rd_chk(OFS_PEND, 32'h00000800);
        wr(OFS_PEND_CLR, 32'h00000800);
        return_from_irq_instr(1'b0);
        $display("test ext done");
    endtask : t_ext

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (2) @(posedge ref_clk);
        arst_n <= 1'b1;
        t_regs;
        t_gate;
        t_prio;
        t_ext;
        tally_and_finish;
    end

    // Watchdog
    initial begin
        repeat (20000) @(posedge ref_clk);
        error_cnt++;
        tally_and_finish;
    end
endmodule : tb
`default_nettype wire
